// [logic/tps_pkg.sv]
// Constants shared by the timer external-clock scaler block
package tps_pkg;
   // ------------------------------------------------------------
   // Option configuration field layout
   // ------------------------------------------------------------
   localparam int unsigned OPT_W          = 8;
   localparam int unsigned OPT_ASSIGN_BIT = 3;
   localparam int unsigned OPT_RATIO_LSB  = 0;
   localparam int unsigned RATIO_W        = 3;
   // ------------------------------------------------------------
   // Scaler and timer widths and reset values
   // ------------------------------------------------------------
   localparam int unsigned SCALER_W       = 8;
   localparam int unsigned TIMER_W        = 8;
   localparam logic [7:0]  SCALER_RST     = 8'h00;
   localparam logic [7:0]  TIMER_RST      = 8'h00;
   localparam logic [7:0]  OPTION_RST     = 8'hff;
   // ------------------------------------------------------------
   // Phase sequencing: four oscillator periods per instruction cycle
   // ------------------------------------------------------------
   localparam int unsigned PHASES         = 4;
   localparam logic [1:0]  PH_ONE         = 2'h0;
   localparam logic [1:0]  PH_TWO         = 2'h1;
   localparam logic [1:0]  PH_FOUR        = 2'h3;
   localparam int unsigned MAX_ERR_TOSC   = 4;
endpackage : tps_pkg

// [logic/tps_timer_scaler.sv]
// Timer external clock path: shared ripple scaler, phase synchroniser and timer count
// ------------------------------------------------------------
// ------------------------------------------------------------
module tps_timer_scaler
   import tps_pkg::*;
(
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               srst,
   // External timer clock, taken as synchronous samples
   input  wire logic               ext_timer_clock_pin,
   // Watchdog tick source and clear
   input  wire logic               watchdog_tick,
   input  wire logic               watchdog_clear_instr,
   // Option register write
   input  wire logic               option_we,
   input  wire logic [OPT_W-1:0]   option_wdata,
   // Timer count write
   input  wire logic               timer_count_we,
   input  wire logic [TIMER_W-1:0] timer_count_wdata,
   // Outputs
   output logic [TIMER_W-1:0]      timer_count_reg,
   output logic                    watchdog_step,
   output logic                    watchdog_unit_clear,
   output logic [1:0]              phase,
   output logic                    scaler_assign_select,
   output logic [RATIO_W-1:0]      scale_ratio_field
);

   // ------------------------------------------------------------
   // Option bits and phase counter
   // ------------------------------------------------------------
   logic [OPT_W-1:0]    option_q;
   logic [1:0]          phase_q;
   logic [SCALER_W-1:0] scaler_q;
   logic                clk_in_q;
   logic                samp_q;
   logic                samp_prev_q;
   logic                wd_in_q;
   logic                step_q;

   // Select one ripple tap, ratio n divides by 2^(n+1)
   function automatic logic tap(input logic [SCALER_W-1:0] s, input logic [RATIO_W-1:0] r);
      tap = s[r];
   endfunction

   // Phase two and phase four are the only points where the timer synchroniser looks at the scaler output
   function automatic logic sample_phase(input logic [1:0] p);
      sample_phase = (p == PH_TWO) || (p == PH_FOUR);
   endfunction

   // ------------------------------------------------------------
   // Limitations
   // ------------------------------------------------------------
   // The ripple chain is modelled as a synchronous binary counter on pin
   // rising edges, so pin levels must each stand for at least one clk.
   // A real ripple chain would let the pin run faster than the phase clock;
   // here the trade is a fully synchronous scaler with no derived clocks.
   // The option register is kept whole, although no port reads it back
   // and only the low four bits steer this block.

   always_ff @(posedge clk) begin
      if (srst) option_q <= OPTION_RST;
      else if (option_we) option_q <= option_wdata;
   end

   assign scaler_assign_select = option_q[OPT_ASSIGN_BIT];
   assign scale_ratio_field    = option_q[OPT_RATIO_LSB +: RATIO_W];

   always_ff @(posedge clk) begin
      if (srst) phase_q <= PH_ONE;
      else phase_q <= phase_q + 2'h1;
   end
   assign phase = phase_q;

   // ------------------------------------------------------------
   // Shared scaler, never visible to software
   // ------------------------------------------------------------
   // No port reads or loads scaler_q; software only clears it indirectly
   logic user_edge;
   logic clear_scaler;
   // Clock rising edges into the scaler come from whichever user owns it
   assign user_edge = scaler_assign_select ? watchdog_tick : (ext_timer_clock_pin & ~clk_in_q);
   assign clear_scaler = (timer_count_we & ~scaler_assign_select)
                       | (watchdog_clear_instr & scaler_assign_select);

   always_ff @(posedge clk) begin
      if (srst) clk_in_q <= 1'b0;
      else clk_in_q <= ext_timer_clock_pin;
   end

   // Counting ripple stages as a binary counter keeps each tap a 50 percent square wave
   always_ff @(posedge clk) begin
      if (srst) scaler_q <= SCALER_RST;
      else if (clear_scaler) scaler_q <= SCALER_RST;
      else if (user_edge) scaler_q <= scaler_q + 8'h01;
   end

   logic scaler_out;
   assign scaler_out = scaler_assign_select ? ext_timer_clock_pin
                                            : tap(scaler_q, scale_ratio_field);

   // ------------------------------------------------------------
   // Phase synchroniser and timer increment
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) samp_q <= 1'b0;
      else if (sample_phase(phase_q)) samp_q <= scaler_out;
   end

   always_ff @(posedge clk) begin
      if (srst) samp_prev_q <= 1'b0;
      else if (phase_q == PH_FOUR) samp_prev_q <= samp_q;
   end

   logic timer_inc;
   // Rising edge seen between two phase-two samples, counted at phase four; worst case error is one cycle
   assign timer_inc = (phase_q == PH_FOUR) & samp_q & ~samp_prev_q;

   always_ff @(posedge clk) begin
      if (srst) timer_count_reg <= TIMER_RST;
      else if (timer_count_we) timer_count_reg <= timer_count_wdata;
      else if (timer_inc) timer_count_reg <= timer_count_reg + 8'h01;
   end

   // ------------------------------------------------------------
   // Watchdog postscaler output
   // ------------------------------------------------------------
   logic wd_src;
   assign wd_src = scaler_assign_select ? tap(scaler_q, scale_ratio_field) : watchdog_tick;

   always_ff @(posedge clk) begin
      if (srst) wd_in_q <= 1'b0;
      else wd_in_q <= wd_src;
   end

   always_ff @(posedge clk) begin
      if (srst) step_q <= 1'b0;
      else step_q <= scaler_assign_select ? (wd_src & ~wd_in_q) : watchdog_tick;
   end
   assign watchdog_step       = step_q;
   assign watchdog_unit_clear = watchdog_clear_instr;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   scaler_reset_a: assert property (@(posedge clk) srst |=> scaler_q == SCALER_RST)
      else $error("scaler not zero after reset");
   timer_clear_a: assert property (@(posedge clk) disable iff (srst)
      timer_count_we && !scaler_assign_select |=> scaler_q == SCALER_RST)
      else $error("timer write did not clear scaler");
   wdt_clear_a: assert property (@(posedge clk) disable iff (srst)
      watchdog_clear_instr && scaler_assign_select |=> scaler_q == SCALER_RST)
      else $error("watchdog clear did not clear scaler");
   sample_phase_a: assert property (@(posedge clk) disable iff (srst)
      !sample_phase(phase_q) |=> $stable(samp_q))
      else $error("sampler changed off phase");
   inc_phase_a: assert property (@(posedge clk) disable iff (srst)
      !$past(srst) && !$past(timer_count_we) && timer_count_reg != $past(timer_count_reg)
      |-> $past(phase_q) == PH_FOUR)
      else $error("timer moved off phase four");
   pass_through_a: assert property (@(posedge clk) disable iff (srst)
      scaler_assign_select |-> scaler_out == ext_timer_clock_pin)
      else $error("clock not passed through");
   wdt_unscaled_a: assert property (@(posedge clk) disable iff (srst)
      !scaler_assign_select && !$past(scaler_assign_select) |=> step_q == $past(watchdog_tick))
      else $error("watchdog scaled while timer owns scaler");
   timer_hold_a: assert property (@(posedge clk) disable iff (srst)
      !scaler_assign_select && !clear_scaler && !user_edge |=> $stable(scaler_q))
      else $error("scaler counted without input edge");
   opt_write_a: assert property (@(posedge clk) disable iff (srst)
      option_we |=> scaler_assign_select == $past(option_wdata[OPT_ASSIGN_BIT]))
      else $error("assignment bit not taken");

   // ------------------------------------------------------------
   // Counting, reset and handover checks
   // ------------------------------------------------------------
   reset_state_a: assert property (@(posedge clk)
      srst |=> phase_q == PH_ONE && timer_count_reg == TIMER_RST && option_q == OPTION_RST)
      else $error("state not cleared by reset");

   phase_step_a: assert property (@(posedge clk) disable iff (srst)
      !$past(srst) |-> phase_q == 2'($past(phase_q) + 2'h1))
      else $error("phase counter skipped");

   scaler_count_a: assert property (@(posedge clk) disable iff (srst)
      !clear_scaler && user_edge |=> scaler_q == 8'($past(scaler_q) + 8'h01))
      else $error("scaler missed an input edge");

   timer_step_a: assert property (@(posedge clk) disable iff (srst)
      !timer_count_we && timer_inc |=> timer_count_reg == 8'($past(timer_count_reg) + 8'h01))
      else $error("timer did not step after sync edge");

   timer_write_a: assert property (@(posedge clk) disable iff (srst)
      timer_count_we |=> timer_count_reg == $past(timer_count_wdata))
      else $error("timer write not taken");

   step_pulse_a: assert property (@(posedge clk) disable iff (srst)
      scaler_assign_select && step_q |=> !step_q)
      else $error("watchdog step longer than one cycle");

   wdt_owner_a: assert property (@(posedge clk) disable iff (srst)
      scaler_assign_select |-> user_edge == watchdog_tick)
      else $error("scaler fed by timer pin while watchdog owns it");

endmodule // tps_timer_scaler

// [verification/tps_ext_clk_src.sv]
// External clock source model for the timer input pin
module tps_ext_clk_src (
   // Clock
   input  wire logic clk,
   // Pin
   output logic      pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pin = 1'b0;
   // Equal high and low times, rests low between bursts; half >= 4 keeps each level past a phase-two sample
   task automatic pulses(input int n, input int half);
      repeat (n) begin
         repeat (half) @(negedge clk);
         pin = 1'b1;
         repeat (half) @(negedge clk);
         pin = 1'b0;
      end
   endtask
endmodule // tps_ext_clk_src

// [verification/testbench.sv]
// Self-checking bench for the timer external clock scaler
module testbench;
   import tps_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 0, srst = 1, tick = 0, wclr = 0, owe = 0, twe = 0, pin, step, uclr, sel;
   logic [7:0] owd = 0, twd = 0, tcnt;
   logic [1:0] ph;
   logic [2:0] ratio;
   int         fails = 0, samples_checked = 0, steps = 0, te, n;
   always #5 clk = ~clk;
   always @(posedge clk) if (step === 1'b1) steps++;
   tps_ext_clk_src u_src (.clk(clk), .pin(pin));
   tps_timer_scaler u_dut (.clk(clk), .srst(srst), .ext_timer_clock_pin(pin), .watchdog_tick(tick),
      .watchdog_clear_instr(wclr), .option_we(owe), .option_wdata(owd), .timer_count_we(twe),
      .timer_count_wdata(twd), .timer_count_reg(tcnt), .watchdog_step(step), .watchdog_unit_clear(uclr),
      .phase(ph), .scaler_assign_select(sel), .scale_ratio_field(ratio));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("fails=%0d samples_checked=%0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic strobe(ref logic s);
      @(negedge clk) s = 1'b1;
      @(negedge clk) s = 1'b0;
   endtask
   // Rising edges of scaler bit r after e input edges from a cleared scaler
   function automatic int div(input int e, input int r);
      return (e + (1 << r)) >> (r + 1);
   endfunction
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      void'($urandom(39107));
      repeat (2) @(negedge clk);
      srst = 0;
      chk(tcnt, 8'h00);
      chk({6'h00, ph}, 8'(PH_ONE));
      chk({sel, ratio}, 8'h0f);
      owd = 8'hff;
      strobe(owe);
      chk({sel, ratio}, 8'h0f);
      n = $urandom_range(3, 9);
      u_src.pulses(n, 4);
      repeat (12) @(negedge clk);
      chk(tcnt, 8'(n));
      for (int r = 0; r < 3; r++) begin
         strobe(wclr);
         te = $urandom_range(0, 255);
         twd = 8'(te);
         strobe(twe);
         owd = 8'(r);
         strobe(owe);
         chk({sel, ratio}, owd);
         chk(tcnt, twd);
         n = $urandom_range(4, 20);
         u_src.pulses(n, 4);
         repeat (12) @(negedge clk);
         chk(tcnt, 8'(te + div(n, r)));
      end
      strobe(wclr);
      strobe(twe);
      owd = 8'h0f;
      strobe(owe);
      strobe(wclr);
      owd = 8'h09;
      strobe(owe);
      wclr = 1;
      #1 chk(uclr, 8'h01);
      @(negedge clk) wclr = 0;
      steps = 0;
      n = $urandom_range(3, 12);
      repeat (n) strobe(tick);
      repeat (4) @(negedge clk);
      chk(8'(steps), 8'(div(n, 1)));
      owd = 8'h01;
      strobe(owe);
      u_src.pulses(1, 4);
      srst = 1;
      @(negedge clk) srst = 0;
      strobe(owe);
      u_src.pulses(1, 4);
      repeat (12) @(negedge clk);
      chk(tcnt, 8'h00);
      finish_test();
   end
   initial begin
      #200000;
      fails++;
      finish_test();
   end
endmodule // testbench
